// ---- rtl/umcl_top.sv ----
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module umcl_top
  import umcl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_shift_out,
  output logic rx_shift_in,
  output logic tx_serial_line,
  input wire logic rx_serial_line,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic dcd_n,
  output logic dtr_n,
  output logic rts_n,
  output logic aux_output_two,
  input wire logic baud_clock_output,
  input wire logic rx_ready_signal,
  output logic irq
);

  logic [7:0] modem_control_r;
  logic [1:0] pin_function_select_r;
  logic [3:0] ien_r;
  logic [3:0] ist_r;
  logic [3:0] msr_prev_r;
  logic [3:0] msr_now;
  logic [7:0] modem_status_reg;
  logic aw_got_r, w_got_r;
  logic [3:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_fire, rd_fire, loop;
  logic aux_two_level;
  logic wr_low_byte;
  logic ist_clear;
  logic [3:0] msr_change;

  // Register address decode, shared by write and clear paths
  function automatic logic addr_hit(input logic [3:0] addr, input logic [3:0] offset);
    addr_hit = (addr == offset);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Modem routing
  assign loop = modem_control_r[CTRL_LOOP];

  // Status inputs: internal controls in loopback, pins otherwise
  always_comb
  begin
    msr_now = 4'h0;
    if (loop)
    begin
      msr_now[0] = modem_control_r[CTRL_RTS];
      msr_now[1] = modem_control_r[CTRL_DTR];
      msr_now[2] = modem_control_r[CTRL_AUX_ONE];
      msr_now[3] = modem_control_r[CTRL_AUX_TWO];
    end
    else
    begin
      msr_now = {~dcd_n, ~ri_n, ~dsr_n, ~cts_n};
    end
  end

  assign modem_status_reg = {msr_now, msr_now ^ msr_prev_r};
  assign rx_shift_in = loop ? tx_shift_out : rx_serial_line;
  assign tx_serial_line = loop ? 1'b1 : tx_shift_out;
  assign dtr_n = loop ? 1'b1 : ~modem_control_r[CTRL_DTR];

  assign rts_n = loop ? 1'b1 : ~modem_control_r[CTRL_RTS];

  // Auxiliary level, inverted sense, inactive in loopback
  assign aux_two_level = loop ? 1'b1 : ~modem_control_r[CTRL_AUX_TWO];

  // Shared pin function select
  always_comb
  begin
    case (umcl_pin_e'(pin_function_select_r))
      UMCL_PIN_AUX: aux_output_two = aux_two_level;
      UMCL_PIN_BAUD: aux_output_two = baud_clock_output;
      UMCL_PIN_RX_READY: aux_output_two = rx_ready_signal;
      default: aux_output_two = aux_two_level;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modem status change interrupts
  assign ist_clear = rd_fire && addr_hit(s_axi_araddr, ADDR_IST);
  assign msr_change = msr_now ^ msr_prev_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      msr_prev_r <= STAT_PREV_RST;
    else if (ce)
      msr_prev_r <= msr_now;
  end

  // One sticky bit per status input; a change in the clearing cycle still sets
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_ist
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          ist_r[gi] <= IST_RST[gi];
        else if (ce)
        begin
          if (msr_change[gi])
            ist_r[gi] <= 1'b1;
          else if (ist_clear)
            ist_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq = |(ist_r & ien_r);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  assign wr_fire = aw_got_r && w_got_r;
  assign s_axi_bresp = 2'h0;
  assign wr_low_byte = wr_fire && w_strb_r[0];

  // Write address capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      aw_addr_r <= 4'h0;
    end
    else if (ce)
    begin
      if (wr_fire)
        aw_got_r <= 1'b0;
      else if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
    end
  end

  // Write data capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_got_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
    end
    else if (ce)
    begin
      if (wr_fire)
        w_got_r <= 1'b0;
      else if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_axi_bvalid <= 1'b0;
    else if (ce)
    begin
      if (wr_fire)
        s_axi_bvalid <= 1'b1;
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Modem control register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      modem_control_r <= CTRL_RST;
    else if (ce && wr_low_byte && addr_hit(aw_addr_r, ADDR_MODEM_CTRL))
      modem_control_r <= {3'h0, w_data_r[4:0]};
  end

  // Pin function select register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin_function_select_r <= PIN_FUNC_RST;
    else if (ce && wr_low_byte && addr_hit(aw_addr_r, ADDR_PIN_FUNC))
      pin_function_select_r <= w_data_r[1:0];
  end

  // Interrupt enable register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ien_r <= IEN_RST;
    else if (ce && wr_low_byte && addr_hit(aw_addr_r, ADDR_IEN))
      ien_r <= w_data_r[3:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= 2'h0;
    end
    else if (ce)
    begin
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        rresp_r <= 2'h0;
        case (s_axi_araddr)
          ADDR_MODEM_CTRL: rdata_r <= {24'h0, modem_control_r};
          ADDR_MODEM_STAT: rdata_r <= {24'h0, modem_status_reg};
          ADDR_PIN_FUNC: rdata_r <= {30'h0, pin_function_select_r};
          ADDR_IEN: rdata_r <= {28'h0, ien_r};
          ADDR_IST: rdata_r <= {28'h0, ist_r};
          default:
          begin
            rdata_r <= 32'h0;
            rresp_r <= 2'h2;
          end
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // umcl_top
`default_nettype wire

// ---- rtl/umcl_pkg.sv ----
package umcl_pkg;
  localparam logic [3:0] ADDR_MODEM_CTRL = 4'h4;
  localparam logic [3:0] ADDR_MODEM_STAT = 4'h6;
  localparam logic [3:0] ADDR_PIN_FUNC = 4'h8;
  localparam logic [3:0] ADDR_IEN = 4'hc;
  localparam logic [3:0] ADDR_IST = 4'h0;
  localparam int CTRL_DTR = 0;
  localparam int CTRL_RTS = 1;
  localparam int CTRL_AUX_ONE = 2;
  localparam int CTRL_AUX_TWO = 3;
  localparam int CTRL_LOOP = 4;
  localparam int STAT_CTS = 4;
  localparam int STAT_DSR = 5;
  localparam int STAT_RI = 6;
  localparam int STAT_DCD = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] PIN_FUNC_RST = 2'h0;
  localparam logic [3:0] IEN_RST = 4'h0;
  localparam logic [3:0] IST_RST = 4'h0;
  localparam logic [3:0] STAT_PREV_RST = 4'h0;
  typedef enum logic [1:0] {
    UMCL_PIN_AUX = 2'b00,
    UMCL_PIN_BAUD = 2'b01,
    UMCL_PIN_RX_READY = 2'b10
  } umcl_pin_e;
endpackage

// ---- tb/umcl_line_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module umcl_line_model (
  input wire logic [4:0] lvl,
  output logic rx_serial_line,
  output logic cts_n,
  output logic dsr_n,
  output logic ri_n,
  output logic dcd_n
);
  assign rx_serial_line = lvl[4];
  assign {dcd_n, ri_n, dsr_n, cts_n} = ~lvl[3:0];
endmodule // umcl_line_model
`default_nettype wire

// ---- tb/umcl_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module umcl_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tx_shift_out,
  input wire logic rx_shift_in,
  input wire logic tx_serial_line,
  input wire logic rx_serial_line,
  input wire logic dtr_n,
  input wire logic rts_n,
  input wire logic aux_output_two,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_a; !tx_serial_line |-> !tx_shift_out && rx_shift_in == rx_serial_line; endproperty
  a_a: assert property (p_a) else $error("a");
  property p_b; tx_serial_line && !tx_shift_out |-> !rx_shift_in && dtr_n && rts_n; endproperty
  a_b: assert property (p_b) else $error("b");
  property p_c; $rose(aresetn) |-> dtr_n && rts_n && aux_output_two && !irq; endproperty
  a_c: assert property (p_c) else $error("c");
  property p_d; $rose(aresetn) |-> tx_serial_line == tx_shift_out; endproperty
  a_d: assert property (p_d) else $error("d");
  property p_e; !dtr_n || !rts_n |-> tx_serial_line == tx_shift_out; endproperty
  a_e: assert property (p_e) else $error("e");
  property p_f; !dtr_n || !rts_n |-> rx_shift_in == rx_serial_line; endproperty
  a_f: assert property (p_f) else $error("f");
  property p_g; (tx_serial_line && !tx_shift_out) [*2] |-> $stable(rx_shift_in); endproperty
  a_g: assert property (p_g) else $error("g");
  property p_h; $rose(tx_serial_line) && !tx_shift_out |-> !rx_shift_in; endproperty
  a_h: assert property (p_h) else $error("h");
endmodule // umcl_monitor
bind umcl_top umcl_monitor mon (.*);
`default_nettype wire

// ---- tb/umcl_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; $display("unexpected %s %h %h", n, e, g); end end
module umcl_top_tb
  import umcl_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, tx_shift_out = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, baud_clock_output = 1'b1, rx_ready_signal = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, q;
  logic [1:0] bq, rq;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [4:0] lvl = 5'h10;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [31:0] s_axi_rdata;
  wire logic rx_shift_in, tx_serial_line, rx_serial_line, cts_n, dsr_n, ri_n, dcd_n;
  wire logic dtr_n, rts_n, aux_output_two, irq;
  int errors = 0, comparisons = 0, cyc = 0;
  umcl_top dut (.*);
  umcl_line_model u_line (.*);
  always #50 aclk = ~aclk;
  task test_done;
    if (errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      test_done;
    end
  end
  task wr(input logic [3:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    bq = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task rd(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    q = s_axi_rdata;
    rq = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_MODEM_CTRL);
    `CK("ctrl", 8'h00, q[7:0])
    wr(ADDR_MODEM_CTRL, 32'hb);
    `CK("bresp", 2'h0, bq)
    `CK("aux", 1'b0, aux_output_two)
    wr(ADDR_PIN_FUNC, 32'h2);
    `CK("rdy", 1'b1, aux_output_two)
    baud_clock_output <= 1'b0;
    wr(ADDR_PIN_FUNC, 32'h1);
    `CK("baud", 1'b0, aux_output_two)
    wr(ADDR_PIN_FUNC, 32'h0);
    wr(ADDR_MODEM_CTRL, 32'h4);
    `CK("pins", 3'h7, {dtr_n, rts_n, aux_output_two})
    tx_shift_out <= 1'b1;
    lvl <= 5'h00;
    @(posedge aclk);
    `CK("line", 2'h2, {tx_serial_line, rx_shift_in})
    lvl <= 5'h0f;
    for (int i = 0; i < 16; i++)
    begin
      wr(ADDR_MODEM_CTRL, 32'h10 | i);
      rd(ADDR_MODEM_STAT);
      `CK("stat", {i[3], i[2], i[0], i[1]}, q[7:4])
    end
    `CK("pins", 4'hf, {dtr_n, rts_n, aux_output_two, tx_serial_line})
    `CK("lpb", 1'b1, rx_shift_in)
    tx_shift_out <= 1'b0;
    lvl <= 5'h1f;
    @(posedge aclk);
    `CK("lpb", 2'h2, {tx_serial_line, rx_shift_in})
    rd(ADDR_IST);
    lvl <= 5'h10;
    wr(ADDR_MODEM_CTRL, 32'h1e);
    `CK("irq", 1'b0, irq)
    wr(ADDR_IEN, 32'hf);
    `CK("irq", 1'b1, irq)
    rd(ADDR_IST);
    `CK("ist", 4'h2, q[3:0])
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_MODEM_CTRL);
    `CK("ctrl", 8'h00, q[7:0])
    `CK("irq", 1'b0, irq)
    rd(4'h2);
    `CK("bad", 32'h0, q)
    `CK("resp", 2'h2, rq)
    test_done;
  end
endmodule // umcl_top_tb
`default_nettype wire
